// ---- src/uart_tx_pkg.sv ----
package uart_tx_pkg;
   // Register byte addresses on the AXI4-Lite slave.
   localparam logic [7:0] ADDR_TX_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_TX_DATA  = 8'h04;
   localparam logic [7:0] ADDR_BAUD_DIV = 8'h08;
   localparam logic [7:0] ADDR_BAUD_CTL = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_CTL  = 8'h10;
   // Field positions in the control/status register.
   localparam int CTRL_TRANSMIT_ENABLE   = 0;
   localparam int CTRL_SYNC   = 1;
   localparam int CTRL_PORT_ENABLE   = 2;
   localparam int CTRL_NINE   = 3;
   localparam int CTRL_BIT9   = 4;
   localparam int CTRL_EMPTY  = 5;
   localparam int CTRL_TBEF   = 6;
   // Field positions in the baud control register.
   localparam int BAUD_INVERT = 0;
   localparam int BAUD_WIDE   = 1;
   // Reset values.
   localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
   // Bits per frame: start, up to nine data, stop.
   localparam logic [3:0]  FRAME_BITS_8 = 4'ha;
   localparam logic [3:0]  FRAME_BITS_9 = 4'hb;
   // Clocks the TBEF flag holds its value after a data write, less one.
   localparam logic [2:0]  FLAG_LAG_CLKS = 3'h7;
   // One instruction cycle is four system clocks.
   localparam logic [1:0]  TCY_CLKS_M1  = 2'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// ---- src/uart_baud_div.sv ----
`timescale 1ns/1ps
module uart_baud_div
   import uart_tx_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   // Control.
   input  wire logic        i_run,
   input  wire logic        i_wide,
   input  wire logic [15:0] i_div,
   // Bit-period tick.
   output logic             o_tick
);
   typedef struct packed {
      logic [15:0] cnt;
   } div_state_t;

   div_state_t st_r;
   div_state_t st_nxt;
   logic [15:0] limit;

   // Narrow mode uses only the low byte of the divisor.
   assign limit = i_wide ? i_div : {8'h00, i_div[7:0]};

   always_comb
   begin
      st_nxt = st_r;
      if (!i_run)
      begin
         st_nxt.cnt = 16'h0000;
      end
      else if (st_r.cnt >= limit)
      begin
         st_nxt.cnt = 16'h0000;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // The tick is decoded from the count, not registered, so the first bit after a
   // load lasts exactly one period like every later bit.
   assign o_tick = i_run && (st_r.cnt >= limit);
endmodule

// ---- src/uart_tx.sv ----
`timescale 1ns/1ps
module uart_tx
   import uart_tx_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   // AXI4-Lite write address and data.
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // AXI4-Lite write response.
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // AXI4-Lite read.
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Serial pin.
   output logic             o_tx_pin,
   output logic             o_tx_pin_oe,
   // Interrupt request towards the core.
   output logic             o_tx_irq
);
   import uart_tx_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_SHIFT = 3'b010,
      S_QUEUE = 3'b100
   } tx_state_t;

   typedef struct packed {
      tx_state_t   fsm;
      logic        tx_en;
      logic        sync;
      logic        port_en;
      logic        nine;
      logic        bit9;
      logic        invert;
      logic        wide;
      logic        irq_en;
      logic [15:0] div;
      logic [8:0]  hold;
      logic [9:0]  shreg;
      logic [3:0]  bits_left;
      logic        flag;
      logic [2:0]  flag_dly;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        pin;
      logic        pin_oe;
      logic        irq;
      logic        aw_rdy;
      logic        w_rdy;
      logic        ar_rdy;
   } top_state_t;

   top_state_t st_r;
   top_state_t st_nxt;
   logic       tick;
   logic       active;

   // Frame image: stop (eight-bit frames only; nine-bit frames get it from the shift fill), data LSB first, start.
   function automatic logic [9:0] frame(input logic [8:0] d, input logic nine);
      frame = nine ? {d, 1'b0} : {1'b1, d[7:0], 1'b0};
   endfunction

   function automatic logic is_reg(input logic [7:0] a);
      is_reg = (a == ADDR_TX_CTRL) || (a == ADDR_TX_DATA) || (a == ADDR_BAUD_DIV)
            || (a == ADDR_BAUD_CTL) || (a == ADDR_IRQ_CTL);
   endfunction

   assign active = st_r.tx_en && !st_r.sync && st_r.port_en;

   uart_baud_div u_div (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (active && st_r.fsm != S_IDLE),
      .i_wide    (st_r.wide),
      .i_div     (st_r.div),
      .o_tick    (tick)
   );

   always_comb
   begin
      logic       wr_fire;
      logic       data_wr;
      logic       frame_end;
      logic       line;
      logic       empty_now;
      wr_fire   = 1'b0;
      data_wr   = 1'b0;
      frame_end = 1'b0;
      line      = 1'b1;
      empty_now = 1'b0;
      st_nxt    = st_r;

      // Write channel: address and data taken in either order.
      if (i_awvalid && !st_r.aw_got)
      begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && !st_r.w_got)
      begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = i_wdata;
         st_nxt.w_strb = i_wstrb;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
      begin
         wr_fire       = 1'b1;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = is_reg(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_r.bvalid && i_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end

      if (wr_fire && st_r.w_strb[0])
      begin
         case (st_r.aw_addr)
            ADDR_TX_CTRL:
            begin
               // Status bits are read-only and ignore writes.
               st_nxt.tx_en   = st_r.w_data[CTRL_TRANSMIT_ENABLE];
               st_nxt.sync    = st_r.w_data[CTRL_SYNC];
               st_nxt.port_en = st_r.w_data[CTRL_PORT_ENABLE];
               st_nxt.nine    = st_r.w_data[CTRL_NINE];
               st_nxt.bit9    = st_r.w_data[CTRL_BIT9];
            end
            ADDR_TX_DATA:  data_wr = 1'b1;
            ADDR_BAUD_DIV: st_nxt.div[7:0] = st_r.w_data[7:0];
            ADDR_BAUD_CTL:
            begin
               st_nxt.invert = st_r.w_data[BAUD_INVERT];
               st_nxt.wide   = st_r.w_data[BAUD_WIDE];
            end
            ADDR_IRQ_CTL:  st_nxt.irq_en = st_r.w_data[0];
            default:       st_nxt.irq_en = st_r.irq_en;
         endcase
      end
      if (wr_fire && st_r.w_strb[1] && st_r.aw_addr == ADDR_BAUD_DIV)
      begin
         st_nxt.div[15:8] = st_r.w_data[15:8];
      end

      // Transmit engine.
      frame_end = tick && st_r.bits_left == 4'h1;
      case (st_r.fsm)
         S_IDLE:
         begin
            if (data_wr && active)
            begin
               st_nxt.shreg     = frame({st_r.bit9, st_r.w_data[7:0]}, st_r.nine);
               st_nxt.bits_left = st_r.nine ? FRAME_BITS_9 : FRAME_BITS_8;
               st_nxt.fsm       = S_SHIFT;
            end
         end
         S_SHIFT:
         begin
            if (data_wr && frame_end)
            begin
               // A write landing on the last tick goes straight to the shifter.
               st_nxt.shreg     = frame({st_r.bit9, st_r.w_data[7:0]}, st_r.nine);
               st_nxt.bits_left = st_r.nine ? FRAME_BITS_9 : FRAME_BITS_8;
            end
            else if (data_wr)
            begin
               st_nxt.hold = {st_r.bit9, st_r.w_data[7:0]};
               st_nxt.fsm  = S_QUEUE;
            end
            else if (frame_end)
            begin
               st_nxt.fsm = S_IDLE;
            end
         end
         S_QUEUE:
         begin
            if (frame_end)
            begin
               st_nxt.shreg     = frame(st_r.hold, st_r.nine);
               st_nxt.bits_left = st_r.nine ? FRAME_BITS_9 : FRAME_BITS_8;
               st_nxt.fsm       = S_SHIFT;
            end
         end
         default: st_nxt.fsm = S_IDLE;
      endcase
      if (tick && st_r.fsm != S_IDLE && !frame_end)
      begin
         st_nxt.shreg     = {1'b1, st_r.shreg[9:1]};
         st_nxt.bits_left = st_r.bits_left - 4'h1;
      end
      if (!active)
      begin
         st_nxt.fsm       = S_IDLE;
         st_nxt.bits_left = 4'h0;
      end

      // Flag holds for two instruction cycles after a data write; the write updates it only if no hold is running.
      empty_now = active ? (st_nxt.fsm != S_QUEUE) : 1'b0;
      if (data_wr && active)
      begin
         st_nxt.flag_dly = FLAG_LAG_CLKS;
      end
      else if (st_r.flag_dly != 3'h0)
      begin
         st_nxt.flag_dly = st_r.flag_dly - 3'h1;
      end
      if (st_r.flag_dly == 3'h0 || !active)
      begin
         st_nxt.flag = empty_now;
      end

      // Pin: mark at idle, optional inversion in async mode only.
      line          = (st_r.fsm == S_IDLE) ? 1'b1 : st_r.shreg[0];
      st_nxt.pin    = line ^ (st_r.invert && !st_r.sync);
      st_nxt.pin_oe = st_r.port_en;
      st_nxt.irq    = st_r.flag && st_r.irq_en;

      // Read channel.
      if (i_arvalid && !st_r.rvalid)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = is_reg(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (i_araddr)
            ADDR_TX_CTRL:  st_nxt.rdata = {25'h0, st_r.flag, st_r.fsm == S_IDLE,
                                           st_r.bit9, st_r.nine, st_r.port_en,
                                           st_r.sync, st_r.tx_en};
            ADDR_BAUD_DIV: st_nxt.rdata = {16'h0, st_r.div};
            ADDR_BAUD_CTL: st_nxt.rdata = {30'h0, st_r.wide, st_r.invert};
            ADDR_IRQ_CTL:  st_nxt.rdata = {31'h0, st_r.irq_en};
            default:       st_nxt.rdata = 32'h0;
         endcase
      end
      else if (st_r.rvalid && i_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end

      // Ready outputs are registered copies so that no port comes from a gate.
      st_nxt.aw_rdy = !st_nxt.aw_got;
      st_nxt.w_rdy  = !st_nxt.w_got;
      st_nxt.ar_rdy = !st_nxt.rvalid;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         st_r          <= '0;
         st_r.fsm      <= S_IDLE;
         st_r.div      <= BAUD_DIV_RST;
         st_r.pin      <= 1'b1;
         st_r.aw_rdy   <= 1'b1;
         st_r.w_rdy    <= 1'b1;
         st_r.ar_rdy   <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_awready   = st_r.aw_rdy;
   assign o_wready    = st_r.w_rdy;
   assign o_bvalid    = st_r.bvalid;
   assign o_bresp     = st_r.bresp;
   assign o_arready   = st_r.ar_rdy;
   assign o_rvalid    = st_r.rvalid;
   assign o_rdata     = st_r.rdata;
   assign o_rresp     = st_r.rresp;
   assign o_tx_pin    = st_r.pin;
   assign o_tx_pin_oe = st_r.pin_oe;
   assign o_tx_irq    = st_r.irq;

   idle_mark_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st_r.fsm == S_IDLE && !st_r.invert |=> o_tx_pin)
      else $error("Idle line not at mark.");
   load_start_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st_r.fsm == S_IDLE && st_nxt.fsm == S_SHIFT |=> !st_r.shreg[0])
      else $error("Frame does not open with a start bit.");
   pin_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st_r.port_en |=> o_tx_pin_oe)
      else $error("Pin not driven with port enabled.");
   disable_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !active |=> st_r.fsm == S_IDLE)
      else $error("Engine running while disabled.");
   irq_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_tx_irq |-> $past(st_r.flag) && $past(st_r.irq_en))
      else $error("Interrupt without flag and enable.");
   queue_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st_r.fsm == S_QUEUE && st_nxt.fsm == S_QUEUE && st_r.flag_dly == 3'h0 |=> !st_r.flag)
      else $error("Flag set while a character is queued.");
   enable_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      $rose(active) |=> st_r.flag)
      else $error("Flag not set on enable.");
   bit_count_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      tick && st_r.fsm != S_IDLE |-> st_r.bits_left != 4'h0)
      else $error("Bit counter underflow.");
   stop_mark_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      tick && st_r.fsm != S_IDLE && st_r.bits_left == 4'h1 |-> st_r.shreg[0])
      else $error("Frame ends without a stop bit.");
   sync_plain_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st_r.sync && st_r.fsm == S_IDLE |=> o_tx_pin)
      else $error("Inversion applied outside async mode.");
   frame_c: cover property (@(posedge i_ref_clk) st_r.fsm == S_SHIFT ##1 st_r.fsm == S_IDLE);
   queue_c: cover property (@(posedge i_ref_clk) st_r.fsm == S_QUEUE ##1 st_r.fsm == S_SHIFT);
   nine_c:  cover property (@(posedge i_ref_clk) st_r.nine && st_r.fsm == S_SHIFT);
endmodule

// ---- bench/uart_rx_model.sv ----
`timescale 1ns/1ps
// Far-end receiver: finds the start edge, then samples each bit at its middle.
// A wrong bit length drifts the sample point out of the bit and corrupts data.
module uart_rx_model (
   // Clock and line.
   input  wire logic        i_ref_clk,
   input  wire logic        i_line,
   // Receiver settings.
   input  wire logic        i_inv,
   input  wire logic        i_nine,
   input  wire logic [15:0] i_period,
   // Received frame.
   output logic [8:0]       o_data,
   output logic             o_stop_ok,
   output int               o_span,
   output int               o_count
);
   int nb;
   int t0;
   int now = 0;
   always @(posedge i_ref_clk)
      now <= now + 1;
   initial
   begin
      o_data = 9'h000;
      o_stop_ok = 1'h0;
      o_span = 0;
      o_count = 0;
      t0 = 0;
      forever
      begin
         @(posedge i_ref_clk);
         if ((i_line ^ i_inv) === 1'h0)
         begin
            o_span = now - t0;
            t0 = now;
            nb = i_nine ? 9 : 8;
            o_data = 9'h000;
            repeat (i_period / 2) @(posedge i_ref_clk);
            for (int i = 0; i < nb; i++)
            begin
               repeat (i_period) @(posedge i_ref_clk);
               o_data[i] = i_line ^ i_inv;
            end
            repeat (i_period) @(posedge i_ref_clk);
            o_stop_ok = ((i_line ^ i_inv) === 1'h1);
            o_count++;
         end
      end
   end
endmodule

// ---- bench/async_uart_transmitter_test.sv ----
`timescale 1ns/1ps
module async_uart_transmitter_test;
   import uart_tx_pkg::*;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, pin, oe, irq;
   logic        inv, nine, b9, line, stp;
   logic [7:0]  awaddr, araddr, c1, c2;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r, br;
   logic [15:0] per;
   logic [8:0]  rxd;
   int          err_count, checked, cnt, span, cyc, n;

   uart_tx DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_awvalid(awvalid), .o_awready(awready),
      .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
      .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_tx_pin(pin),
      .o_tx_pin_oe(oe), .o_tx_irq(irq));
   // The pin is pulled to mark while nothing drives it.
   assign line = oe ? pin : 1'h1;
   uart_rx_model rx (.i_ref_clk(clk), .i_line(line), .i_inv(inv), .i_nine(nine),
      .i_period(per), .o_data(rxd), .o_stop_ok(stp), .o_span(span), .o_count(cnt));

   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awvalid <= 1'h1;
      awaddr <= a;
      wvalid <= 1'h1;
      wdata <= v;
      bready <= 1'h1;
      forever
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            br = bresp;
            bready <= 1'h0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
      @(posedge clk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      forever
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            v = rdata;
            s = rresp;
            rready <= 1'h0;
            break;
         end
      end
   endtask

   // Waits for frame number k and compares it; gap also bounds the start-to-start time.
   task automatic frame(input int k, input logic [8:0] e, input logic gap);
      int lo;
      lo = (nine ? 11 : 10) * per;
      while (cnt < k)
         @(posedge clk);
      check("rx data", {23'h0, e}, {23'h0, rxd});
      check("rx stop", 32'h1, {31'h0, stp});
      if (gap)
         check("gap", 32'h1, {31'h0, span >= lo && span <= lo + 4});
   endtask

   initial
   begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = 48'h0;
      {inv, nine, per, err_count, checked, cyc} = '0;
      per = 16'h0004;
      void'($urandom(61540));
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      check("pin idle", 32'h1, {31'h0, pin});
      check("oe", 32'h0, {31'h0, oe});
      rd(ADDR_TX_CTRL, d, r);
      check("empty", 32'h1, {31'h0, d[CTRL_EMPTY]});
      rd(8'h14, d, r);
      check("bad resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      check("bad data", 32'h0, d);
      wr(8'h14, 32'h0);
      check("bad wresp", {30'h0, RESP_SLVERR}, {30'h0, br});
      wr(ADDR_BAUD_DIV, 32'h0103);
      check("div wresp", {30'h0, RESP_OKAY}, {30'h0, br});
      rd(ADDR_BAUD_DIV, d, r);
      check("div", 32'h0103, d);
      wr(ADDR_TX_CTRL, 32'h45);
      repeat (3) @(posedge clk);
      check("oe on", 32'h1, {31'h0, oe});
      rd(ADDR_TX_CTRL, d, r);
      check("flag", 32'h1, {31'h0, d[CTRL_TBEF]});
      wr(ADDR_IRQ_CTL, 32'h1);
      repeat (3) @(posedge clk);
      check("irq", 32'h1, {31'h0, irq});
      wr(ADDR_IRQ_CTL, 32'h0);
      $display("setup test done");
      for (int k = 0; k < 6; k++)
      begin
         nine = k[0];
         b9 = 1'($urandom);
         c1 = (k == 0) ? 8'h00 : 8'($urandom);
         c2 = (k == 0) ? 8'hff : 8'($urandom);
         n = cnt;
         wr(ADDR_TX_CTRL, {27'h0, b9, nine, 3'h5});
         wr(ADDR_TX_DATA, {24'h0, c1});
         wr(ADDR_TX_DATA, {24'h0, c2});
         repeat (10) @(posedge clk);
         rd(ADDR_TX_CTRL, d, r);
         check("flag busy", 32'h0, {31'h0, d[CTRL_TBEF]});
         check("shifter busy", 32'h0, {31'h0, d[CTRL_EMPTY]});
         frame(n + 1, {nine & b9, c1}, 1'h0);
         frame(n + 2, {nine & b9, c2}, 1'h1);
      end
      repeat (20) @(posedge clk);
      rd(ADDR_TX_CTRL, d, r);
      check("drained", 32'h3, {30'h0, d[CTRL_TBEF], d[CTRL_EMPTY]});
      $display("frame test done");
      nine = 1'h0;
      wr(ADDR_TX_CTRL, 32'h5);
      wr(ADDR_BAUD_DIV, 32'h0005);
      wr(ADDR_BAUD_CTL, 32'h3);
      per = 16'h0006;
      repeat (3) @(posedge clk);
      check("pin inv", 32'h0, {31'h0, pin});
      // The polarity flip looks like a start edge to the receiver, so let it pass.
      inv = 1'h1;
      repeat (80) @(posedge clk);
      n = cnt;
      wr(ADDR_TX_DATA, 32'h00a5);
      frame(n + 1, 9'h0a5, 1'h0);
      wr(ADDR_BAUD_CTL, 32'h0);
      inv = 1'h0;
      repeat (80) @(posedge clk);
      $display("invert test done");
      wr(ADDR_TX_DATA, 32'h0000);
      repeat (12) @(posedge clk);
      wr(ADDR_TX_CTRL, 32'h4);
      repeat (2) @(posedge clk);
      check("stop pin", 32'h1, {31'h0, pin});
      rd(ADDR_TX_CTRL, d, r);
      check("stop empty", 32'h1, {31'h0, d[CTRL_EMPTY]});
      repeat (80) @(posedge clk);
      n = cnt;
      wr(ADDR_TX_CTRL, 32'h7);
      wr(ADDR_TX_DATA, 32'h0055);
      wr(ADDR_BAUD_CTL, 32'h1);
      repeat (3) @(posedge clk);
      check("sync inv", 32'h1, {31'h0, pin});
      wr(ADDR_BAUD_CTL, 32'h0);
      repeat (80) @(posedge clk);
      check("sync quiet", n, cnt);
      wr(ADDR_TX_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      check("oe off", 32'h0, {31'h0, oe});
      $display("disable test done");
      end_of_test();
   end
endmodule
